// *** sbt_regs.vh ***
// constants for the system board timing support block
`ifndef SBT_REGS_VH
`define SBT_REGS_VH
// crystal divisors
`define SBT_PCLK_DIV 3'd3
`define SBT_BURST_DIV 3'd4
// bus cycle lengths in processor clocks
`define SBT_MEM_CLKS 3'd4
`define SBT_IO_CLKS 3'd5
`define SBT_DMA_CLKS 3'd5
`define SBT_REF_CLKS 3'd4
// processor clock in which a dma transfer may wait on ready
`define SBT_DMA_WAIT_T 3'd2
// timer prescale: five processor clocks give 1.05 us
`define SBT_TMR_PRE 3'd5
// timer channel assignment
`define SBT_TMR_TOD 0
`define SBT_TMR_REF 1
`define SBT_TMR_SPK 2
// interrupt level assignment
`define SBT_IRQ_TOD 0
`define SBT_IRQ_KBD 1
// mask port decode on io address bits 9..4, and its two values
`define SBT_NMI_PORT 6'h0a
`define SBT_NMI_ON 8'h80
`define SBT_NMI_OFF 8'h00
// keyboard diagnostic request hold time
`define SBT_CLK_MHZ 40
`define SBT_DIAG_MS 20
`define SBT_DIAG_CYC (`SBT_DIAG_MS * 1000 * `SBT_CLK_MHZ)
`endif

// *** sbt_div.v ***
// divider of the crystal tick into a clock level and its edge pulse
`timescale 1ns/1ps
module sbt_div #(
    parameter [2:0] N = 3'd3
) (
    input wire clk,       // system clock
    input wire sys_rst,   // async reset, active high
    input wire tick,      // one pulse per input period
    output reg clk_ff,    // divided clock level
    output reg edge_ff    // one pulse per divided period
);
    reg [2:0] cnt_ff;
    wire [2:0] nxt_cnt;

    assign nxt_cnt = (cnt_ff == N - 3'd1) ? 3'd0 : cnt_ff + 3'd1;

    always @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            // start on the last count so the first divided period is whole
            cnt_ff <= N - 3'd1;
            clk_ff <= 1'b0;
            edge_ff <= 1'b0;
        end
        else
        begin
            edge_ff <= tick && (cnt_ff == N - 3'd1);
            if (tick)
            begin
                cnt_ff <= nxt_cnt;
                // high for the first half period, rounded down
                clk_ff <= (nxt_cnt < (N >> 1)) || (nxt_cnt == 3'd0);
            end
        end
    end
endmodule

// *** sbt_tmr.v ***
// one 16-bit reloading timer channel
`timescale 1ns/1ps
module sbt_tmr (
    input wire clk,          // system clock
    input wire sys_rst,      // async reset, active high
    input wire tick,         // count pulse, 1.05 us apart
    input wire gate,         // counting allowed
    input wire load,         // pulse: take init as count
    input wire [15:0] init,  // reload value, zero means 65536
    output reg tc_ff,        // pulse at end of each period
    output reg sq_ff         // square wave, toggles each period
);
    reg [15:0] cnt_ff;
    reg [15:0] rld_ff;

    always @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            cnt_ff <= 16'h0000;
            rld_ff <= 16'h0000;
            tc_ff <= 1'b0;
            sq_ff <= 1'b0;
        end
        else
        begin
            tc_ff <= 1'b0;
            if (load)
            begin
                rld_ff <= init;
                cnt_ff <= init;
            end
            else if (tick && gate)
            begin
                if (cnt_ff == 16'h0001)
                begin
                    cnt_ff <= rld_ff;
                    tc_ff <= 1'b1;
                    sq_ff <= ~sq_ff;
                end
                else
                begin
                    cnt_ff <= cnt_ff - 16'h0001;
                end
            end
        end
    end
endmodule

// *** sbt_top.v ***
// system board timing support: clocks, bus cycles, timers, interrupts
// Function
// - processor clock is crystal divided by three
// - burst clock is crystal divided by four
// - memory bus cycle lasts four processor clocks
// - io bus cycle lasts five processor clocks
// - dma transfer five clocks, stretched by ready
// - refresh dma cycle lasts four clocks
// - timer one requests refresh memory read cycles
// - three dma channels go to slots
// - timer zero drives interrupt level zero
// - timer two generates speaker tones
// - keyboard raises level one per scan code
// - six interrupt levels come from slots
// - parity errors reported on nonmaskable interrupt
// - keyboard interface can request keyboard diagnostics
// - software can read eight configuration switches
// - three 16-bit timers, 1.05 us resolution
// - nmi masked at reset, port a0 controls
`timescale 1ns/1ps
`include "sbt_regs.vh"
module sbt_top #(
    parameter DIAG_CYC = `SBT_DIAG_CYC
) (
    input wire clk,               // system clock, 40 mhz
    input wire sys_rst,           // async reset, active high
    input wire xtal_tick,         // one pulse per crystal period
    output wire proc_clk,         // processor clock level
    output wire burst_clk,        // colour burst clock level
    input wire cpu_req,           // processor bus cycle wanted
    input wire cpu_is_io,         // cycle kind: 1 io, 0 memory
    output reg cpu_ack_ff,        // pulse: processor cycle ended
    input wire proc_rdy,          // ready line, low stretches dma
    input wire [2:0] dreq_slot,   // dma requests, slot channels
    output reg [2:0] dack_slot_ff, // dma acknowledges to slots
    output reg ref_dack_ff,       // refresh channel acknowledge
    output reg memr_board_ff,     // memory read to board memory
    output reg memr_slot_ff,      // memory read to slot memory
    output reg cyc_busy_ff,       // bus cycle in progress
    output reg [2:0] cyc_t_ff,    // current processor clock of cycle
    input wire [2:0] tmr_load,    // pulse per channel: load value
    input wire [47:0] tmr_init,   // channel 2,1,0 reload values
    input wire spk_gate,          // speaker timer gate
    output wire spk_tone,         // speaker tone square wave
    input wire [5:0] irq_slot,    // interrupt requests from slots
    output reg [7:0] irq_lvl_ff,  // interrupt levels to controller
    input wire kbd_code_done,     // pulse: scan code complete
    input wire kbd_irq_clr,       // pulse: keyboard request serviced
    input wire kbd_diag_req,      // pulse: ask keyboard for diagnostic
    output reg kbd_clk_hold_ff,   // keyboard clock held for request
    input wire io_wr,             // pulse: processor io write
    input wire io_rd,             // processor io read in progress
    input wire [9:0] io_addr,     // io address
    input wire [7:0] io_data,     // io write data
    input wire par_err,           // pulse: memory parity error
    input wire par_clr,           // pulse: clear parity error
    output reg nmi_ff,            // nonmaskable interrupt request
    input wire [7:0] sw_in,       // configuration switch pack
    input wire sw_rd,             // pulse: software reads switches
    output reg [7:0] sw_data_ff,  // switch value last read
    input wire card_sel,          // special slot card selected
    output wire board_buf_oe      // board data buffer drives bus
);
    localparam [3:0] ST_IDLE = 4'b0001;
    localparam [3:0] ST_CPU = 4'b0010;
    localparam [3:0] ST_DMA = 4'b0100;
    localparam [3:0] ST_REF = 4'b1000;

    wire pclk_tick;
    wire [2:0] tmr_tc;
    wire [2:0] tmr_sq;
    reg [2:0] pre_ff;
    reg tmr_tick_ff;
    reg [3:0] st_ff;
    reg [3:0] nxt_st;
    reg [2:0] len_ff;
    reg [2:0] nxt_len;
    reg [2:0] nxt_t;
    reg [1:0] ch_ff;
    reg [1:0] nxt_ch;
    reg ref_pend_ff;
    reg kbd_irq_ff;
    reg nmi_en_ff;
    reg par_ff;
    reg [31:0] diag_cnt_ff;
    wire ref_grant;
    wire cyc_end;
    wire nmi_port;

    // crystal dividers
    sbt_div #(
        .N(`SBT_PCLK_DIV)
    ) u_pclk (
        .clk(clk),
        .sys_rst(sys_rst),
        .tick(xtal_tick),
        .clk_ff(proc_clk),
        .edge_ff(pclk_tick)
    );

    sbt_div #(
        .N(`SBT_BURST_DIV)
    ) u_burst (
        .clk(clk),
        .sys_rst(sys_rst),
        .tick(xtal_tick),
        .clk_ff(burst_clk),
        .edge_ff()
    );

    // timer prescale to 1.05 us
    always @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            pre_ff <= 3'd0;
            tmr_tick_ff <= 1'b0;
        end
        else
        begin
            tmr_tick_ff <= pclk_tick && (pre_ff == `SBT_TMR_PRE - 3'd1);
            if (pclk_tick)
            begin
                if (pre_ff == `SBT_TMR_PRE - 3'd1)
                    pre_ff <= 3'd0;
                else
                    pre_ff <= pre_ff + 3'd1;
            end
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < 3; gi = gi + 1)
        begin : g_tmr
            sbt_tmr u_tmr (
                .clk(clk),
                .sys_rst(sys_rst),
                .tick(tmr_tick_ff),
                .gate((gi == `SBT_TMR_SPK) ? spk_gate : 1'b1),
                .load(tmr_load[gi]),
                .init(tmr_init[gi*16 +: 16]),
                .tc_ff(tmr_tc[gi]),
                .sq_ff(tmr_sq[gi])
            );
        end
    endgenerate

    assign spk_tone = tmr_sq[`SBT_TMR_SPK];

    // bus cycle sequencer; refresh first, then slot dma, then processor
    assign cyc_end = pclk_tick && (st_ff != ST_IDLE) &&
                     (cyc_t_ff == len_ff - 3'd1);
    assign ref_grant = pclk_tick && (st_ff == ST_IDLE) && ref_pend_ff;

    always @*
    begin
        nxt_st = st_ff;
        nxt_len = len_ff;
        nxt_t = cyc_t_ff;
        nxt_ch = ch_ff;
        case (st_ff)
            ST_IDLE:
            begin
                nxt_t = 3'd0;
                if (pclk_tick)
                begin
                    if (ref_pend_ff)
                    begin
                        nxt_st = ST_REF;
                        nxt_len = `SBT_REF_CLKS;
                    end
                    else if (dreq_slot != 3'b000)
                    begin
                        nxt_st = ST_DMA;
                        nxt_len = `SBT_DMA_CLKS;
                        if (dreq_slot[0])
                            nxt_ch = 2'd1;
                        else if (dreq_slot[1])
                            nxt_ch = 2'd2;
                        else
                            nxt_ch = 2'd3;
                    end
                    else if (cpu_req)
                    begin
                        nxt_st = ST_CPU;
                        if (cpu_is_io)
                            nxt_len = `SBT_IO_CLKS;
                        else
                            nxt_len = `SBT_MEM_CLKS;
                    end
                end
            end
            ST_CPU, ST_REF, ST_DMA:
            begin
                if (pclk_tick)
                begin
                    if (cyc_t_ff == len_ff - 3'd1)
                    begin
                        nxt_st = ST_IDLE;
                        nxt_t = 3'd0;
                        nxt_ch = 2'd0;
                    end
                    else if (st_ff == ST_DMA && !proc_rdy &&
                             cyc_t_ff == `SBT_DMA_WAIT_T)
                        nxt_t = cyc_t_ff;
                    else
                        nxt_t = cyc_t_ff + 3'd1;
                end
            end
            default:
            begin
                nxt_st = ST_IDLE;
                nxt_t = 3'd0;
                nxt_ch = 2'd0;
            end
        endcase
    end

    always @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            st_ff <= ST_IDLE;
            len_ff <= `SBT_MEM_CLKS;
            cyc_t_ff <= 3'd0;
            ch_ff <= 2'd0;
            cyc_busy_ff <= 1'b0;
            cpu_ack_ff <= 1'b0;
            dack_slot_ff <= 3'b000;
            ref_dack_ff <= 1'b0;
            memr_board_ff <= 1'b0;
            memr_slot_ff <= 1'b0;
        end
        else
        begin
            st_ff <= nxt_st;
            len_ff <= nxt_len;
            cyc_t_ff <= nxt_t;
            ch_ff <= nxt_ch;
            cyc_busy_ff <= (nxt_st != ST_IDLE);
            cpu_ack_ff <= cyc_end && (st_ff == ST_CPU);
            dack_slot_ff[0] <= (nxt_st == ST_DMA) && (nxt_ch == 2'd1);
            dack_slot_ff[1] <= (nxt_st == ST_DMA) && (nxt_ch == 2'd2);
            dack_slot_ff[2] <= (nxt_st == ST_DMA) && (nxt_ch == 2'd3);
            ref_dack_ff <= (nxt_st == ST_REF);
            // dummy read seen by board and slot memory alike
            memr_board_ff <= (nxt_st == ST_REF) && (nxt_t != 3'd0);
            memr_slot_ff <= (nxt_st == ST_REF) && (nxt_t != 3'd0);
        end
    end

    // refresh request from timer one; a new request beats the grant
    always @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            ref_pend_ff <= 1'b0;
        else if (tmr_tc[`SBT_TMR_REF])
            ref_pend_ff <= 1'b1;
        else if (ref_grant)
            ref_pend_ff <= 1'b0;
    end

    // interrupt levels and keyboard request
    always @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            kbd_irq_ff <= 1'b0;
            irq_lvl_ff <= 8'h00;
        end
        else
        begin
            if (kbd_code_done)
                kbd_irq_ff <= 1'b1;
            else if (kbd_irq_clr)
                kbd_irq_ff <= 1'b0;
            irq_lvl_ff[`SBT_IRQ_TOD] <= tmr_sq[`SBT_TMR_TOD];
            irq_lvl_ff[`SBT_IRQ_KBD] <= kbd_irq_ff || kbd_code_done;
            irq_lvl_ff[7:2] <= irq_slot;
        end
    end

    // keyboard diagnostic request: hold the keyboard clock for a while
    always @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            diag_cnt_ff <= 32'h00000000;
            kbd_clk_hold_ff <= 1'b0;
        end
        else if (kbd_diag_req && !kbd_clk_hold_ff)
        begin
            diag_cnt_ff <= DIAG_CYC[31:0] - 32'h00000001;
            kbd_clk_hold_ff <= 1'b1;
        end
        else if (kbd_clk_hold_ff)
        begin
            if (diag_cnt_ff == 32'h00000000)
                kbd_clk_hold_ff <= 1'b0;
            else
                diag_cnt_ff <= diag_cnt_ff - 32'h00000001;
        end
    end

    // parity error reporting behind the mask port
    assign nmi_port = io_wr && (io_addr[9:4] == `SBT_NMI_PORT);

    always @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            nmi_en_ff <= 1'b0;
            par_ff <= 1'b0;
            nmi_ff <= 1'b0;
        end
        else
        begin
            if (nmi_port && io_data == `SBT_NMI_ON)
                nmi_en_ff <= 1'b1;
            else if (nmi_port && io_data == `SBT_NMI_OFF)
                nmi_en_ff <= 1'b0;
            if (par_err)
                par_ff <= 1'b1;
            else if (par_clr)
                par_ff <= 1'b0;
            nmi_ff <= nmi_en_ff && (par_ff || par_err);
        end
    end

    // configuration switch capture
    always @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            sw_data_ff <= 8'h00;
        else if (sw_rd)
            sw_data_ff <= sw_in;
    end

    // board buffer stays off the bus while the special slot answers
    assign board_buf_oe = io_rd && !card_sel;
endmodule

// *** sbt_card.sv ***
// slot card model: dma requester and special-slot card select
`timescale 1ns/1ps
module sbt_card #(
    parameter [9:0] BASE = 10'h300
) (
    input wire clk, // system clock
    input wire sys_rst, // async reset, active high
    input wire [2:0] want, // pulse per channel: start a transfer
    input wire [2:0] dack_slot, // acknowledges from the board
    input wire [9:0] io_addr, // io address on the channel
    output reg [2:0] dreq_ff, // dma requests to the board
    output wire card_sel // card answers its own addresses
);
    // a request stays up until the board acknowledges that channel
    always @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            dreq_ff <= 3'h0;
        else
            dreq_ff <= (dreq_ff | want) & ~dack_slot;
    end

    assign card_sel = io_addr[9:5] == BASE[9:5];
endmodule

// *** sbt_top_asserts.sv ***
// concurrent checks on the ports of the timing support block
`timescale 1ns/1ps
module sbt_top_chk #(
    parameter DIAG_CYC = 16
) (
    input wire clk, // clock
    input wire sys_rst, // reset
    input wire proc_clk, // processor clock
    input wire burst_clk, // burst clock
    input wire cpu_ack_ff, // cycle end
    input wire cpu_is_io, // io cycle kind
    input wire [2:0] cyc_t_ff, // clock index
    input wire ref_dack_ff, // refresh ack
    input wire memr_board_ff, // board read
    input wire memr_slot_ff, // slot read
    input wire [7:0] irq_lvl_ff, // levels
    input wire kbd_code_done, // scan code
    input wire kbd_clk_hold_ff, // diag hold
    input wire io_wr, // io write
    input wire [9:0] io_addr, // io address
    input wire [7:0] io_data, // io data
    input wire par_err, // parity error
    input wire nmi_ff // nmi
);
    reg nmi_en_ff;
    reg [31:0] hold_cnt_ff;
    wire mask_wr = io_wr && io_addr[9:4] == 6'h0a;

    default clocking @(posedge clk);
    endclocking
    default disable iff (sys_rst);

    // shadow of the mask bit and length of the diagnostic hold
    always @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            nmi_en_ff <= 1'h0;
            hold_cnt_ff <= 32'h0;
        end
        else
        begin
            if (mask_wr && io_data == 8'h80)
                nmi_en_ff <= 1'h1;
            else if (mask_wr && io_data == 8'h00)
                nmi_en_ff <= 1'h0;
            hold_cnt_ff <= kbd_clk_hold_ff ? hold_cnt_ff + 32'h1 : 32'h0;
        end
    end

    proc_div_a: assert property (
        $rose(proc_clk) |=> !proc_clk [*2] ##1 proc_clk)
        else $error("processor clock not one in three");
    burst_div_a: assert property (
        $rose(burst_clk) |-> burst_clk [*2] ##1 !burst_clk [*2] ##1 burst_clk)
        else $error("burst clock not two of four");
    bus_len_a: assert property (
        cpu_ack_ff |-> $past(cyc_t_ff) == (cpu_is_io ? 3'h4 : 3'h3))
        else $error("bus cycle ended at wrong clock");
    ref_len_a: assert property (
        $fell(ref_dack_ff) |-> $past(cyc_t_ff) == 3'h3)
        else $error("refresh cycle not four clocks");
    refresh_read_a: assert property (
        memr_board_ff |-> memr_slot_ff && ref_dack_ff && cyc_t_ff != 3'h0)
        else $error("refresh read not on both memories");
    kbd_irq_a: assert property (
        kbd_code_done |=> irq_lvl_ff[1])
        else $error("scan code gave no level one request");
    nmi_report_a: assert property (
        par_err && nmi_en_ff |=> nmi_ff)
        else $error("parity error not reported");
    nmi_mask_a: assert property (
        !nmi_en_ff |=> !nmi_ff)
        else $error("nmi raised while masked");
    diag_len_a: assert property (
        $fell(kbd_clk_hold_ff) |-> hold_cnt_ff == DIAG_CYC)
        else $error("diagnostic hold of wrong length");

    cover property ($fell(ref_dack_ff));
    cover property (cpu_ack_ff && cpu_is_io);
    cover property ($fell(kbd_clk_hold_ff));
endmodule

bind sbt_top sbt_top_chk #(.DIAG_CYC(DIAG_CYC)) u_sbt_top_chk (.*);

// *** sbt_top_tb.sv ***
// self-checking bench for the timing support block
`timescale 1ns/1ps
module sbt_top_tb;
    logic clk = 1'h0, sys_rst = 1'h1, cpu_req = 1'h0, cpu_is_io = 1'h0;
    logic proc_rdy = 1'h1, spk_gate = 1'h0, io_wr = 1'h0, io_rd = 1'h0;
    logic [5:0] pl = 6'h0, irq_slot = 6'h0;
    logic [2:0] tmr_load = 3'h0, want = 3'h0, dk;
    logic [47:0] tmr_init = 48'h0;
    logic [9:0] io_addr = 10'h0;
    logic [7:0] io_data = 8'h0, sw_in = 8'h0;
    wire cpu_ack_ff, cyc_busy_ff, ref_dack_ff, spk_tone, kbd_clk_hold_ff;
    wire nmi_ff, board_buf_oe, card_sel;
    wire [2:0] dack_slot_ff, cyc_t_ff, dreq_slot;
    wire [7:0] irq_lvl_ff, sw_data_ff;
    int failures = 0, samples_checked = 0, cycles = 0;

    always #12.5 clk = ~clk;

    sbt_top #(.DIAG_CYC(16)) u_sbt_top (
        .clk(clk), .sys_rst(sys_rst), .xtal_tick(1'h1), .proc_clk(),
        .burst_clk(), .cpu_req(cpu_req), .cpu_is_io(cpu_is_io),
        .cpu_ack_ff(cpu_ack_ff), .proc_rdy(proc_rdy), .dreq_slot(dreq_slot),
        .dack_slot_ff(dack_slot_ff), .ref_dack_ff(ref_dack_ff),
        .memr_board_ff(), .memr_slot_ff(), .cyc_busy_ff(cyc_busy_ff),
        .cyc_t_ff(cyc_t_ff), .tmr_load(tmr_load), .tmr_init(tmr_init),
        .spk_gate(spk_gate), .spk_tone(spk_tone), .irq_slot(irq_slot),
        .irq_lvl_ff(irq_lvl_ff), .kbd_code_done(pl[0]), .kbd_irq_clr(pl[1]),
        .kbd_diag_req(pl[2]), .kbd_clk_hold_ff(kbd_clk_hold_ff),
        .io_wr(io_wr), .io_rd(io_rd), .io_addr(io_addr), .io_data(io_data),
        .par_err(pl[3]), .par_clr(pl[4]), .nmi_ff(nmi_ff), .sw_in(sw_in),
        .sw_rd(pl[5]), .sw_data_ff(sw_data_ff), .card_sel(card_sel),
        .board_buf_oe(board_buf_oe));

    sbt_card u_sbt_card (.clk(clk), .sys_rst(sys_rst), .want(want),
        .dack_slot(dack_slot_ff), .io_addr(io_addr), .dreq_ff(dreq_slot),
        .card_sel(card_sel));

    task automatic give_verdict();
        $display("compared %0d, failures %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            failures++;
            give_verdict();
        end
    end

    task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
        samples_checked++;
        if (got !== exp)
        begin
            failures++;
            $display("unexpected %s: expected %0h seen %0h", what, exp, got);
        end
    endtask

    function automatic logic pick(int k);
        case (k)
            0: pick = cyc_busy_ff;
            1: pick = |dack_slot_ff;
            2: pick = ref_dack_ff;
            3: pick = kbd_clk_hold_ff;
            4: pick = spk_tone;
            default: pick = irq_lvl_ff[0];
        endcase
    endfunction

    // clocks the chosen output stays high once it is next seen high
    task automatic span(int k, output int n);
        int i;
        for (i = 0; i < 400 && pick(k) !== 1'h1; i++) @(posedge clk) #1;
        for (n = 0; n < 400 && pick(k) === 1'h1; n++)
            @(posedge clk) #1 dk = dk | dack_slot_ff;
    endtask

    task automatic pulse(logic [5:0] m);
        @(posedge clk);
        pl <= m;
        @(posedge clk);
        pl <= 6'h0;
        #1;
    endtask

    task automatic stall();
        int i;
        for (i = 0; i < 100 && cyc_t_ff !== 3'h2; i++) @(posedge clk) #1;
        @(posedge clk);
        proc_rdy <= 1'h0;
        repeat (3) @(posedge clk);
        proc_rdy <= 1'h1;
    endtask

    task automatic io_write(logic [7:0] d);
        @(posedge clk);
        io_addr <= 10'h0a0;
        io_data <= d;
        io_wr <= 1'h1;
        @(posedge clk);
        io_wr <= 1'h0;
        repeat (2) @(posedge clk);
    endtask

    task automatic t_bus();
        int n;
        for (int io = 0; io < 2; io++)
        begin
            @(posedge clk);
            cpu_is_io <= io[0];
            cpu_req <= 1'h1;
            span(0, n);
            chk("bus clocks", io ? 15 : 12, n);
            chk("cycle end", 1, cpu_ack_ff);
            @(posedge clk);
            cpu_req <= 1'h0;
        end
        $display("bus cycle test done");
    endtask

    task automatic t_dma();
        int n;
        for (int ch = 0; ch < 3; ch++)
        begin
            @(posedge clk);
            want <= 3'h1 << ch;
            @(posedge clk);
            want <= 3'h0;
            dk = 3'h0;
            fork
                span(1, n);
                if (ch == 2)
                    stall();
            join
            chk("dma clocks", ch == 2 ? 18 : 15, n);
            chk("dma lines", 3'h1 << ch, dk);
        end
        $display("dma test done");
    endtask

    task automatic t_misc();
        int n;
        irq_slot <= 6'h2a;
        pulse(6'h01);
        chk("keyboard level", 1, irq_lvl_ff[1]);
        pulse(6'h02);
        @(posedge clk) #1;
        chk("keyboard clear", 0, irq_lvl_ff[1]);
        chk("slot levels", 6'h2a, irq_lvl_ff[7:2]);
        pulse(6'h08);
        chk("nmi masked", 0, nmi_ff);
        io_write(8'h80);
        pulse(6'h10);
        pulse(6'h08);
        chk("nmi raised", 1, nmi_ff);
        io_write(8'h00);
        chk("nmi disabled", 0, nmi_ff);
        pulse(6'h04);
        span(3, n);
        chk("diag hold", 16, n);
        sw_in <= 8'ha5;
        pulse(6'h20);
        sw_in <= 8'h3c;
        chk("switch value", 8'ha5, sw_data_ff);
        io_rd <= 1'h1;
        io_addr <= 10'h300;
        @(posedge clk) #1;
        chk("card buffer", 0, board_buf_oe);
        io_addr <= 10'h3f8;
        @(posedge clk) #1;
        chk("board buffer", 1, board_buf_oe);
        io_rd <= 1'h0;
        $display("interrupt, nmi, keyboard and switch test done");
    endtask

    task automatic t_timer();
        int n;
        logic v;
        @(posedge clk);
        tmr_init <= {16'h0003, 16'h0000, 16'h0002};
        tmr_load <= 3'h5;
        spk_gate <= 1'h1;
        @(posedge clk);
        tmr_load <= 3'h0;
        repeat (2) span(4, n);
        chk("tone half period", 45, n);
        repeat (2) span(5, n);
        chk("time base half period", 30, n);
        spk_gate <= 1'h0;
        repeat (3) @(posedge clk);
        v = spk_tone;
        repeat (100) @(posedge clk);
        chk("tone gated", v, spk_tone);
        tmr_init[31:16] <= 16'h0004;
        tmr_load <= 3'h2;
        @(posedge clk);
        tmr_load <= 3'h0;
        repeat (2) span(2, n);
        chk("refresh clocks", 12, n);
        $display("timer and refresh test done");
    endtask

    initial
    begin
        repeat (20) @(posedge clk);
        sys_rst <= 1'h0;
        @(posedge clk);
        t_bus();
        t_dma();
        t_misc();
        t_timer();
        give_verdict();
    end
endmodule
